/* File: core/blink_divider.sv */
// shared blink phase for every flashing indicator
`timescale 1ns/1ps
`include "mixer_defines.svh"

module blink_divider
	import mixer_pkg::*;
#(
	parameter int unsigned HALF_CYC = `BLINK_HALF_CYC
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic en_i,
	// phase
	output logic      phase_o
);

	blink_state_t st_q;
	blink_state_t st_d;

	always_comb begin
		st_d = st_q;
		if (st_q.cnt >= HALF_CYC - 1) begin
			st_d.cnt   = 32'h0;
			st_d.phase = !st_q.phase;
		end else begin
			st_d.cnt = st_q.cnt + 32'h1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= '0;
		end else if (en_i) begin
			st_q <= st_d;
		end
	end

	assign phase_o = st_q.phase;

endmodule : blink_divider

/* File: core/button_conditioner.sv */
// debounce and edge detect for one panel button
`timescale 1ns/1ps
`include "mixer_defines.svh"

module button_conditioner
	import mixer_pkg::*;
#(
	parameter int unsigned DEB_CYC = `DEBOUNCE_CYC
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic en_i,
	// button
	input  wire logic raw_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);

	deb_state_t st_q;
	deb_state_t st_d;

	always_comb begin
		st_d      = st_q;
		st_d.rise = 1'b0;
		st_d.fall = 1'b0;
		if (raw_i != st_q.level) begin
			if (st_q.cnt >= DEB_CYC - 1) begin
				st_d.cnt   = 32'h0;
				st_d.level = raw_i;
				st_d.rise  = raw_i;
				st_d.fall  = !raw_i;
			end else begin
				st_d.cnt = st_q.cnt + 32'h1;
			end
		end else begin
			st_d.cnt = 32'h0;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= '0;
		end else if (en_i) begin
			st_q <= st_d;
		end
	end

	assign level_o = st_q.level;
	assign rise_o  = st_q.rise;
	assign fall_o  = st_q.fall;

endmodule : button_conditioner

/* File: core/mixer_defines.svh */
// constants for the mixer front-panel mode controller
`ifndef MIXER_DEFINES_SVH
`define MIXER_DEFINES_SVH

// channel and mix field sizes
`define CH_NUM           16
`define CH_IDX_W         4
`define VOL_W            5
`define PAN_W            3

// reset and clear values
`define VOL_CLEAR        5'h00
`define PAN_CENTRE       3'h2
`define BOOT_SLOT        4'h0

// button positions in the conditioned vector
`define BTN_NUM          20
`define BTN_RECALL       16
`define BTN_GROUP        17
`define BTN_SOLO         18
`define BTN_MUTE         19

// timing
`define CLK_HZ           200000000
`define DEBOUNCE_MS      5
`define BLINK_HALF_MS    125
`define CONFIRM_MS       600
`define DEBOUNCE_CYC     ((`CLK_HZ / 1000) * `DEBOUNCE_MS)
`define BLINK_HALF_CYC   ((`CLK_HZ / 1000) * `BLINK_HALF_MS)
`define CONFIRM_CYC      ((`CLK_HZ / 1000) * `CONFIRM_MS)

`endif

/* File: core/mixer_panel_mode_controller.sv */
// front-panel mode controller for a sixteen-channel monitor mixer
`timescale 1ns/1ps
`include "mixer_defines.svh"

module mixer_panel_mode_controller
	import mixer_pkg::*;
#(
	parameter int unsigned DEB_CYC     = `DEBOUNCE_CYC,
	parameter int unsigned BLINK_CYC   = `BLINK_HALF_CYC,
	parameter int unsigned CONFIRM_CYC = `CONFIRM_CYC
) (
	// clock, reset, enable
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	input  wire logic         en_i,
	// front panel buttons
	input  wire logic [15:0]  chan_btn_i,
	input  wire logic         recall_btn_i,
	input  wire logic         group_btn_i,
	input  wire logic         solo_btn_i,
	input  wire logic         mute_btn_i,
	// control sources
	input  wire logic         remote_sel_i,
	input  wire cmd_t         knob_cmd_i,
	input  wire cmd_t         midi_cmd_i,
	input  wire cmd_t         remote_cmd_i,
	// mix and audio gating
	output mix_t              mix_o,
	output logic [15:0]       audible_o,
	// indicators
	output logic [15:0]       sel_led_o,
	output logic [15:0]       mute_led_o,
	output logic              recall_led_o,
	output logic              group_led_o,
	output logic              solo_led_o
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [`CH_IDX_W-1:0] low_idx(input logic [`CH_NUM-1:0] v);
		low_idx = '0;
		for (int i = `CH_NUM - 1; i >= 0; i--) begin
			if (v[i]) begin
				low_idx = i[`CH_IDX_W-1:0];
			end
		end
	endfunction : low_idx

	function automatic logic [`CH_NUM-1:0] one_hot(input logic [`CH_IDX_W-1:0] idx);
		one_hot      = '0;
		one_hot[idx] = 1'b1;
	endfunction : one_hot

	function automatic logic [`CH_NUM-1:0] solo_mask(input logic [`CH_IDX_W-1:0] idx,
		input logic [`CH_NUM-1:0] grp);
		solo_mask = grp[idx] ? (grp | one_hot(idx)) : one_hot(idx);
	endfunction : solo_mask

	function automatic mix_t cleared(input mix_t m);
		cleared = m;
		for (int i = 0; i < `CH_NUM; i++) begin
			cleared[i].vol = `VOL_CLEAR;
			cleared[i].pan = `PAN_CENTRE;
		end
	endfunction : cleared

	function automatic ctrl_state_t reset_state();
		reset_state          = '0;
		reset_state.mode     = MODE_MIX;
		reset_state.mix      = cleared('0);
		reset_state.audible  = '1;
		reset_state.sel_led  = 16'h0001;
		for (int s = 0; s < `CH_NUM; s++) begin
			reset_state.presets[s] = cleared('0);
		end
	endfunction : reset_state

	localparam ctrl_state_t RST_ST = reset_state();

	////////////////////////////////////////////////////////////////////////////
	// button conditioning and blink

	logic [`BTN_NUM-1:0] btn_raw;
	logic [`BTN_NUM-1:0] btn_lvl;
	logic [`BTN_NUM-1:0] btn_rise;
	logic [`BTN_NUM-1:0] btn_fall;
	logic                blink;

	assign btn_raw = {mute_btn_i, solo_btn_i, group_btn_i, recall_btn_i, chan_btn_i};

	generate
		for (genvar b = 0; b < `BTN_NUM; b++) begin : g_btn
			button_conditioner #(.DEB_CYC(DEB_CYC)) u_cond (
				.clk_i     (clk_i),
				.reset_n_i (reset_n_i),
				.en_i      (en_i),
				.raw_i     (btn_raw[b]),
				.level_o   (btn_lvl[b]),
				.rise_o    (btn_rise[b]),
				.fall_o    (btn_fall[b])
			);
		end
	endgenerate

	blink_divider #(.HALF_CYC(BLINK_CYC)) u_blink (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.en_i      (en_i),
		.phase_o   (blink)
	);

	////////////////////////////////////////////////////////////////////////////
	// mode logic

	ctrl_state_t          st_q;
	ctrl_state_t          st_d;
	cmd_t                 cmd;
	logic                 pnl_ok;
	logic [`CH_NUM-1:0]   ch_p;
	logic [`CH_NUM-1:0]   ch_r;
	logic                 rec_p;
	logic                 grp_p;
	logic                 solo_p;
	logic                 mute_p;
	logic                 save_cond;
	logic                 write_ev;
	logic                 clear_ev;
	logic                 load_ev;
	logic                 mute_ev;
	logic [`CH_IDX_W-1:0] load_slot;
	mix_t                 slot_mix;
	logic                 mute_sel;

	always_comb begin
		// remote position locks out panel and midi, local ignores remote
		cmd       = remote_sel_i ? remote_cmd_i
			: (midi_cmd_i.valid ? midi_cmd_i : knob_cmd_i);
		pnl_ok    = !remote_sel_i;
		ch_p      = pnl_ok ? btn_rise[`CH_NUM-1:0] : '0;
		ch_r      = pnl_ok ? btn_fall[`CH_NUM-1:0] : '0;
		rec_p     = pnl_ok && btn_rise[`BTN_RECALL];
		grp_p     = pnl_ok && btn_rise[`BTN_GROUP];
		solo_p    = pnl_ok && btn_rise[`BTN_SOLO];
		mute_p    = pnl_ok && btn_rise[`BTN_MUTE];
		save_cond = pnl_ok && btn_lvl[`BTN_RECALL] && btn_lvl[`BTN_GROUP];
		write_ev  = 1'b0;
		clear_ev  = 1'b0;
		load_ev   = 1'b0;
		mute_ev   = 1'b0;
		load_slot = low_idx(ch_p);
		st_d      = st_q;

		if (!st_q.booted) begin
			st_d.mix    = st_q.presets[`BOOT_SLOT];
			st_d.booted = 1'b1;
			load_slot   = `BOOT_SLOT;
		end else begin
			if (cmd.valid) begin
				case (cmd.op)
					CMD_VOL:    st_d.mix[st_q.sel].vol = cmd.value;
					CMD_PAN:    st_d.mix[st_q.sel].pan = cmd.value[`PAN_W-1:0];
					CMD_MUTE:   st_d.mix[st_q.sel].mute = cmd.value[0];
					CMD_SELECT: st_d.sel = cmd.arg;
					CMD_SAVE: begin
						st_d.presets[cmd.arg] = st_q.mix;
						write_ev = 1'b1;
					end
					CMD_RECALL: begin
						load_slot = cmd.arg;
						st_d.mix  = st_q.presets[cmd.arg];
						load_ev   = 1'b1;
					end
					CMD_CLEAR: begin
						st_d.mix = cleared(st_q.mix);
						clear_ev = 1'b1;
					end
					default: st_d.mix = st_q.mix;
				endcase
			end
			if (save_cond) begin
				st_d.mode = MODE_SAVE;
				st_d.held = 1'b0;
				st_d.arm  = 1'b0;
				if (st_q.mode == MODE_SAVE && |ch_r) begin
					st_d.presets[low_idx(ch_r)] = st_q.mix;
					write_ev = 1'b1;
				end
			end else begin
				case (st_q.mode)
					MODE_SAVE: st_d.mode = MODE_MIX;
					MODE_MIX: begin
						if (rec_p) begin
							st_d.mode = MODE_RECALL;
						end else if (grp_p) begin
							st_d.mode = MODE_GROUP;
						end else if (solo_p) begin
							st_d.mode = MODE_SOLO;
							st_d.held = 1'b0;
							st_d.arm  = 1'b0;
						end else if (mute_p) begin
							st_d.mix[st_q.sel].mute = !st_q.mix[st_q.sel].mute;
							mute_ev = 1'b1;
						end else if (|ch_p) begin
							st_d.sel = low_idx(ch_p);
						end
					end
					MODE_RECALL: begin
						if (|ch_p) begin
							st_d.mix  = st_q.presets[low_idx(ch_p)];
							load_ev   = 1'b1;
							st_d.mode = MODE_MIX;
						end else if (mute_p) begin
							st_d.mix  = cleared(st_q.mix);
							clear_ev  = 1'b1;
							st_d.mode = MODE_MIX;
						end else if (rec_p || grp_p || solo_p) begin
							st_d.mode = MODE_MIX;
						end
					end
					MODE_GROUP: begin
						if (|ch_p) begin
							st_d.grp = st_q.grp ^ one_hot(low_idx(ch_p));
						end else if (grp_p || solo_p || mute_p) begin
							st_d.mode = MODE_MIX;
						end else if (rec_p) begin
							st_d.mode = MODE_RECALL;
						end
					end
					MODE_SOLO: begin
						if (solo_p || rec_p || grp_p || mute_p) begin
							st_d.mode = MODE_MIX;
							st_d.held = 1'b0;
							st_d.arm  = 1'b0;
						end else if (st_q.held) begin
							if (|ch_p) begin
								st_d.sel = low_idx(ch_p);
							end
						end else if (|ch_p && btn_lvl[`BTN_SOLO]) begin
							st_d.sel = low_idx(ch_p);
							st_d.arm = 1'b1;
						end else if (|ch_p) begin
							st_d.sel  = low_idx(ch_p);
							st_d.mode = MODE_MIX;
						end else if (st_q.arm && |ch_r && btn_lvl[`BTN_SOLO]) begin
							st_d.held = 1'b1;
							st_d.arm  = 1'b0;
						end else if (st_q.arm && !btn_lvl[`BTN_SOLO]) begin
							st_d.arm = 1'b0;
						end
					end
					default: st_d.mode = MODE_MIX;
				endcase
			end
		end

		// confirmation flash after a write
		if (write_ev) begin
			st_d.conf_cnt = CONFIRM_CYC;
		end else if (st_q.conf_cnt != 32'h0) begin
			st_d.conf_cnt = st_q.conf_cnt - 32'h1;
		end

		// indicators
		if (st_d.conf_cnt != 32'h0) begin
			st_d.sel_led  = {`CH_NUM{blink}};
			st_d.mute_led = {`CH_NUM{blink}};
		end else begin
			st_d.sel_led = one_hot(st_d.sel)
				| ((st_d.mode == MODE_GROUP) ? st_d.grp : '0);
			for (int i = 0; i < `CH_NUM; i++) begin
				st_d.mute_led[i] = st_d.mix[i].mute;
			end
		end
		st_d.recall_led = blink && (st_d.mode == MODE_RECALL
			|| st_d.mode == MODE_SAVE);
		st_d.group_led  = blink && (st_d.mode == MODE_GROUP
			|| st_d.mode == MODE_SAVE);
		st_d.solo_led   = (st_d.mode == MODE_SOLO) && (!st_d.held || blink);
		for (int i = 0; i < `CH_NUM; i++) begin
			st_d.audible[i] = !st_d.mix[i].mute;
		end
		if (st_d.mode == MODE_SOLO) begin
			st_d.audible = st_d.audible & solo_mask(st_d.sel, st_d.grp);
		end
		slot_mix = st_q.presets[load_slot];
		mute_sel = st_q.mix[st_q.sel].mute;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= RST_ST;
		end else if (en_i) begin
			st_q <= st_d;
		end
	end

	assign mix_o        = st_q.mix;
	assign audible_o    = st_q.audible;
	assign sel_led_o    = st_q.sel_led;
	assign mute_led_o   = st_q.mute_led;
	assign recall_led_o = st_q.recall_led;
	assign group_led_o  = st_q.group_led;
	assign solo_led_o   = st_q.solo_led;

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	property p_boot_load;
		en_i && !st_q.booted |=> st_q.mix == $past(slot_mix);
	endproperty
	a_boot_load: assert property (p_boot_load) else $error("boot preset not loaded");

	property p_recall_load;
		en_i && st_q.booted && load_ev |=> st_q.mix == $past(slot_mix);
	endproperty
	a_recall_load: assert property (p_recall_load) else $error("recall load wrong");

	property p_save_held;
		st_q.mode == MODE_SAVE && $past(en_i) |-> $past(save_cond);
	endproperty
	a_save_held: assert property (p_save_held) else $error("save without both buttons");

	property p_save_flash;
		st_q.mode == MODE_SAVE |-> recall_led_o == group_led_o;
	endproperty
	a_save_flash: assert property (p_save_flash) else $error("save leds out of step");

	property p_confirm_start;
		en_i && write_ev |=> st_q.conf_cnt == CONFIRM_CYC ##1 sel_led_o == '0 || sel_led_o == '1;
	endproperty
	a_confirm_start: assert property (p_confirm_start) else $error("no confirm flash");

	property p_clear_all;
		en_i && clear_ev |=> st_q.mix == cleared($past(st_q.mix));
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("clear all failed");

	property p_remote_lock;
		en_i && st_q.booted && remote_sel_i && !remote_cmd_i.valid |=> $stable(st_q.mix);
	endproperty
	a_remote_lock: assert property (p_remote_lock) else $error("mix changed in remote");

	property p_selected_lit;
		st_q.conf_cnt == 32'h0 |-> sel_led_o[st_q.sel];
	endproperty
	a_selected_lit: assert property (p_selected_lit) else $error("selected led dark");

	property p_solo_gate;
		st_q.mode == MODE_SOLO |-> (audible_o & ~solo_mask(st_q.sel, st_q.grp)) == '0;
	endproperty
	a_solo_gate: assert property (p_solo_gate) else $error("solo leaks audio");

	property p_solo_led;
		st_q.mode == MODE_SOLO && !st_q.held |-> solo_led_o;
	endproperty
	a_solo_led: assert property (p_solo_led) else $error("solo led dark");

	property p_mute_toggle;
		en_i && mute_ev |=> st_q.mix[st_q.sel].mute != $past(mute_sel);
	endproperty
	a_mute_toggle: assert property (p_mute_toggle) else $error("mute not changed");

	c_save_write: cover property (en_i && write_ev && st_q.mode == MODE_SAVE);
	c_clear_all:  cover property (en_i && clear_ev && st_q.mode == MODE_RECALL);
	c_held_solo:  cover property (st_q.mode == MODE_SOLO && st_q.held);
	c_recall:     cover property (en_i && load_ev && st_q.mode == MODE_RECALL);

endmodule : mixer_panel_mode_controller

/* File: core/mixer_pkg.sv */
// types for the mixer front-panel mode controller
`include "mixer_defines.svh"

package mixer_pkg;

	typedef enum logic [2:0] {
		MODE_MIX,
		MODE_RECALL,
		MODE_GROUP,
		MODE_SOLO,
		MODE_SAVE
	} mode_t;

	typedef enum logic [2:0] {
		CMD_VOL,
		CMD_PAN,
		CMD_MUTE,
		CMD_SELECT,
		CMD_SAVE,
		CMD_RECALL,
		CMD_CLEAR
	} cmd_op_t;

	typedef struct packed {
		logic                 valid;
		cmd_op_t              op;
		logic [`CH_IDX_W-1:0] arg;
		logic [`VOL_W-1:0]    value;
	} cmd_t;

	typedef struct packed {
		logic [`VOL_W-1:0] vol;
		logic [`PAN_W-1:0] pan;
		logic              mute;
	} chan_mix_t;

	typedef chan_mix_t [`CH_NUM-1:0] mix_t;
	typedef mix_t [`CH_NUM-1:0]      bank_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic        level;
		logic        rise;
		logic        fall;
	} deb_state_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic        phase;
	} blink_state_t;

	typedef struct packed {
		mode_t                mode;
		logic                 booted;
		logic                 held;
		logic                 arm;
		logic [`CH_IDX_W-1:0] sel;
		logic [`CH_NUM-1:0]   grp;
		logic [31:0]          conf_cnt;
		mix_t                 mix;
		bank_t                presets;
		logic [`CH_NUM-1:0]   sel_led;
		logic [`CH_NUM-1:0]   mute_led;
		logic [`CH_NUM-1:0]   audible;
		logic                 recall_led;
		logic                 group_led;
		logic                 solo_led;
	} ctrl_state_t;

endpackage : mixer_pkg

/* File: tb/mixer_panel_mode_controller_bench.sv */
// self-checking bench for the mixer mode controller
`timescale 1ns/1ps
`include "mixer_defines.svh"

module mixer_panel_mode_controller_bench;
	import mixer_pkg::*;
	localparam int DEB = 4;
	localparam int BLK = 4;
	localparam int CNF = 16;
	localparam int MW  = $bits(mix_t);
	logic        clk_i     = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [15:0] chan_btn, sel_led, mute_led, audible;
	logic        rec_btn, grp_btn, solo_btn, mute_btn, remote_sel;
	logic        rec_led, grp_led, solo_led;
	cmd_t        knob_cmd, midi_cmd, remote_cmd;
	mix_t        mix, em, saved;
	mix_t        bank [16];
	logic [18:0] hi, lo;
	logic        in_phase;
	logic [3:0]  sel, k;
	logic [4:0]  v;
	int          n_errors = 0;
	int          compares = 0;
	int          seed     = 65789;
	wire  [18:0] leds     = {solo_led, grp_led, rec_led, sel_led};

	always #2.5 clk_i = ~clk_i;

	mixer_panel_mode_controller #(.DEB_CYC(DEB), .BLINK_CYC(BLK), .CONFIRM_CYC(CNF))
	i_mixer_panel_mode_controller (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .en_i(1'b1),
		.chan_btn_i(chan_btn), .recall_btn_i(rec_btn), .group_btn_i(grp_btn),
		.solo_btn_i(solo_btn), .mute_btn_i(mute_btn), .remote_sel_i(remote_sel),
		.knob_cmd_i(knob_cmd), .midi_cmd_i(midi_cmd), .remote_cmd_i(remote_cmd),
		.mix_o(mix), .audible_o(audible), .sel_led_o(sel_led), .mute_led_o(mute_led),
		.recall_led_o(rec_led), .group_led_o(grp_led), .solo_led_o(solo_led));

	panel_model #(.DEB_CYC(DEB)) i_panel_model (
		.clk_i(clk_i), .chan_btn_o(chan_btn), .recall_btn_o(rec_btn),
		.group_btn_o(grp_btn), .solo_btn_o(solo_btn), .mute_btn_o(mute_btn),
		.remote_sel_o(remote_sel), .knob_cmd_o(knob_cmd), .midi_cmd_o(midi_cmd),
		.remote_cmd_o(remote_cmd));

	//////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (n_errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [MW-1:0] seen, input logic [MW-1:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [15:0] mutes(input mix_t m);
		for (int i = 0; i < 16; i++) begin
			mutes[i] = m[i].mute;
		end
	endfunction : mutes

	function automatic mix_t apply(input mix_t m, input cmd_op_t op, input logic [3:0] s,
		input logic [4:0] val);
		apply = m;
		case (op)
			CMD_VOL:  apply[s].vol  = val;
			CMD_PAN:  apply[s].pan  = val[2:0];
			CMD_MUTE: apply[s].mute = val[0];
			CMD_CLEAR: begin
				for (int i = 0; i < 16; i++) begin
					apply[i].vol = `VOL_CLEAR;
					apply[i].pan = `PAN_CENTRE;
				end
			end
			default: apply = m;
		endcase
	endfunction : apply

	// mix-mode view of mix, selection, mute and audio gating
	task automatic look();
		#1;
		check(mix, em);
		check(16'h1 << sel, sel_led);
		check(mute_led, mutes(em));
		check(audible, 16'(~mutes(em)));
	endtask : look

	task automatic cmd(input int src, input cmd_op_t op, input logic [3:0] a,
		input logic [4:0] val);
		i_panel_model.send(src, op, a, val);
		if ((src == 2) == remote_sel) begin
			if (op == CMD_SELECT) begin
				sel = a;
			end else if (op == CMD_SAVE) begin
				bank[a] = em;
				repeat (CNF) @(posedge clk_i);
			end else if (op == CMD_RECALL) begin
				em = bank[a];
			end else begin
				em = apply(em, op, sel, val);
			end
		end
		look();
	endtask : cmd

	task automatic watch(input int n);
		hi = '0;
		lo = '0;
		in_phase = 1'b1;
		repeat (n) begin
			@(posedge clk_i);
			#1;
			hi |= leds;
			lo |= ~leds;
			if (rec_led !== grp_led) begin
				in_phase = 1'b0;
			end
		end
	endtask : watch

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		em = {16{chan_mix_t'{`VOL_CLEAR, `PAN_CENTRE, 1'b0}}};
		sel = 4'h0;
		for (int i = 0; i < 16; i++) begin
			bank[i] = em;
		end
		look();
		check({rec_led, grp_led, solo_led}, 3'h0);
		for (int p = 0; p < 2; p++) begin
			i_panel_model.set_remote(p[0]);
			repeat (24) begin
				cmd($unsigned($random(seed)) % 3, cmd_op_t'($unsigned($random(seed)) % 7),
					4'($random(seed)), 5'($random(seed)));
			end
		end
		i_panel_model.tap(32'(sel ^ 4'h1));
		look();
		i_panel_model.set_remote(1'b0);
		i_panel_model.tap(`BTN_MUTE);
		em[sel].mute = ~em[sel].mute;
		look();
		// save into a random slot, written on channel release
		k = 4'(1 + ($unsigned($random(seed)) % 15));
		v = 5'($random(seed));
		cmd(0, CMD_SELECT, k, 5'h00);
		cmd(1, CMD_VOL, 4'h0, v);
		saved = em;
		bank[k] = em;
		i_panel_model.set_btns(20'h30000, 1'b1);
		watch(16);
		check(hi[17:16] & lo[17:16], 2'h3);
		check(in_phase, 1'b1);
		i_panel_model.set_btns(20'h1 << k, 1'b1);
		watch(8);
		check(hi[15:0] & lo[15:0], 16'h0000);
		i_panel_model.set_btns(20'h1 << k, 1'b0);
		watch(12);
		check(hi[15:0] & lo[15:0], 16'hFFFF);
		i_panel_model.set_btns(20'h30000, 1'b0);
		repeat (CNF) @(posedge clk_i);
		cmd(0, CMD_VOL, 4'h0, ~v);
		// recall the slot back
		i_panel_model.tap(`BTN_RECALL);
		watch(16);
		check(hi[16] & lo[16], 1'b1);
		i_panel_model.tap(32'(k));
		em = saved;
		cmd(0, CMD_SELECT, k, 5'h00);
		i_panel_model.tap(`BTN_RECALL);
		i_panel_model.tap(`BTN_MUTE);
		em = apply(em, CMD_CLEAR, 4'h0, 5'h00);
		#1;
		check(mix, em);
		// build and dismantle a group
		i_panel_model.tap(`BTN_GROUP);
		watch(16);
		check(hi[17] & lo[17], 1'b1);
		i_panel_model.tap(32'(k ^ 4'h8));
		i_panel_model.tap(32'(k ^ 4'h4));
		#1;
		check({sel_led[k ^ 4'h8], sel_led[k ^ 4'h4]}, 2'h3);
		i_panel_model.tap(32'(k ^ 4'h8));
		i_panel_model.tap(32'(k ^ 4'h4));
		#1;
		check({sel_led[k ^ 4'h8], sel_led[k ^ 4'h4]}, 2'h0);
		i_panel_model.tap(`BTN_GROUP);
		#1;
		check(grp_led, 1'b0);
		// solo the selected channel
		cmd(0, CMD_MUTE, 4'h0, 5'h00);
		i_panel_model.tap(`BTN_SOLO);
		watch(12);
		check({hi[18], lo[18]}, 2'h2);
		check(audible, 16'h1 << sel);
		i_panel_model.tap(`BTN_SOLO);
		look();
		// held solo: channel tapped while solo held, then hop to another
		i_panel_model.set_btns(20'h40000, 1'b1);
		i_panel_model.tap(32'(k ^ 4'h2));
		i_panel_model.set_btns(20'h40000, 1'b0);
		i_panel_model.tap(32'(k ^ 4'h1));
		watch(12);
		check({hi[18], lo[18]}, 2'h3);
		check(audible, 16'(~mutes(em)) & (16'h1 << (k ^ 4'h1)));
		i_panel_model.tap(`BTN_SOLO);
		sel = k ^ 4'h1;
		look();
		i_panel_model.glitch(32'(sel ^ 4'h2), DEB - 2);
		look();
		finish_test();
	end

	initial begin
		#(5 * 60000);
		n_errors++;
		finish_test();
	end
endmodule : mixer_panel_mode_controller_bench

/* File: tb/panel_model.sv */
// front panel, midi port and remote surface model
`timescale 1ns/1ps
`include "mixer_defines.svh"

module panel_model
	import mixer_pkg::*;
#(
	parameter int unsigned DEB_CYC = 4
) (
	// clock
	input  wire logic   clk_i,
	// buttons and switch
	output logic [15:0] chan_btn_o,
	output logic        recall_btn_o,
	output logic        group_btn_o,
	output logic        solo_btn_o,
	output logic        mute_btn_o,
	output logic        remote_sel_o,
	// command sources
	output cmd_t        knob_cmd_o,
	output cmd_t        midi_cmd_o,
	output cmd_t        remote_cmd_o
);
	logic [`BTN_NUM-1:0] btn_q    = '0;
	logic                remote_q = 1'b0;
	cmd_t                cmd_q [3] = '{default: '0};

	assign chan_btn_o   = btn_q[15:0];
	assign recall_btn_o = btn_q[`BTN_RECALL];
	assign group_btn_o  = btn_q[`BTN_GROUP];
	assign solo_btn_o   = btn_q[`BTN_SOLO];
	assign mute_btn_o   = btn_q[`BTN_MUTE];
	assign remote_sel_o = remote_q;
	assign knob_cmd_o   = cmd_q[0];
	assign midi_cmd_o   = cmd_q[1];
	assign remote_cmd_o = cmd_q[2];

	//////////////////////////////////////////////////////////////////////////////
	// level held past the debounce span, then event settles
	task automatic set_btns(input logic [`BTN_NUM-1:0] mask, input logic lvl);
		@(posedge clk_i);
		btn_q <= lvl ? (btn_q | mask) : (btn_q & ~mask);
		repeat (DEB_CYC + 3) @(posedge clk_i);
	endtask : set_btns

	task automatic tap(input int idx);
		set_btns(`BTN_NUM'(1) << idx, 1'b1);
		set_btns(`BTN_NUM'(1) << idx, 1'b0);
	endtask : tap

	// bounce shorter than the debounce span
	task automatic glitch(input int idx, input int n);
		@(posedge clk_i);
		btn_q[idx] <= 1'b1;
		repeat (n) @(posedge clk_i);
		btn_q[idx] <= 1'b0;
		repeat (DEB_CYC + 3) @(posedge clk_i);
	endtask : glitch

	task automatic set_remote(input logic lvl);
		@(posedge clk_i);
		remote_q <= lvl;
	endtask : set_remote

	// one-cycle command, fields scrambled when idle
	task automatic send(input int src, input cmd_op_t op, input logic [3:0] a,
		input logic [4:0] val);
		@(posedge clk_i);
		cmd_q[src] <= cmd_t'{1'b1, op, a, val};
		@(posedge clk_i);
		cmd_q[src] <= cmd_t'({1'b0, ~cmd_q[src][11:0]});
	endtask : send
endmodule : panel_model
